//--- pkg/pwr_seq_pkg.sv
// power sequencer package: register map, field layout, states, pin groups
//
// Summary of operation
// - auto field 1 or 5 lets dpll stop
// - auto field 0 keeps dpll locked always
// - memory control reset on core return from off or open-switch, warm reset
// - dependency enable wakes peripheral with core
// - previous state in bits 1:0, off=0, on=3
// - graphics interface clock enable forces dpll locked
// - bypass decision ignores graphics functional clock
// - idle request held until lock actually seen
package pwr_seq_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_AUTO      = 8'h00;
    localparam logic [7:0] ADDR_DOM       = 8'h04;
    localparam logic [7:0] ADDR_GFX       = 8'h08;
    localparam logic [7:0] ADDR_PREV_CORE = 8'h0C;
    localparam logic [7:0] ADDR_PREV_PER  = 8'h10;
    localparam logic [7:0] ADDR_STAT      = 8'h14;

    // dpll_autoidle_control field codes
    localparam logic [2:0] AUTO_MANUAL = 3'h0;
    localparam logic [2:0] AUTO_STOP   = 3'h1;
    localparam logic [2:0] AUTO_ALT    = 3'h5;
    localparam logic [2:0] AUTO_RST    = 3'h0;

    // power state codes
    localparam logic [1:0] PS_OFF  = 2'h0;
    localparam logic [1:0] PS_OPEN_SWITCH_RETENTION = 2'h1;
    localparam logic [1:0] PS_CLOSED_SWITCH_RETENTION = 2'h2;
    localparam logic [1:0] PS_ON   = 2'h3;

    // field positions
    localparam int DOM_CORE_LSB = 0;
    localparam int DOM_PER_LSB  = 2;
    localparam int DOM_DEP_BIT  = 4;
    localparam int GFX_FCLK_BIT = 0;
    localparam int GFX_ICLK_BIT = 1;
    localparam logic [1:0] GFX_RST = 2'h0;

    // dpll control states, gray along lock-idle-bypass-relock
    typedef enum logic [1:0] {
        D_LOCK = 2'b00,
        D_IDLE = 2'b01,
        D_BYP  = 2'b11,
        D_RELK = 2'b10
    } dpll_e;

    // asynchronous inputs from outside
    typedef struct packed {
        logic sleepReq;
        logic coreWake;
        logic perWake;
        logic warmReset;
        logic dpllLocked;
    } pins_s;

    // sequencer outputs
    typedef struct packed {
        logic       dpllBypass;
        logic       memIdleReq;
        logic       memCtrlReset;
        logic [1:0] coreState;
        logic [1:0] perState;
    } pmOut_s;

endpackage

//--- logic/core_dpll_power_domain_sequencer.sv
// core dpll and power domain sequencer with register port
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module core_dpll_power_domain_sequencer (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // register port
    input  wire logic [7:0]          regAddr,
    input  wire logic [31:0]         regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [31:0]         regRdata,
    // pins
    input  wire pwr_seq_pkg::pins_s  pins,
    output pwr_seq_pkg::pmOut_s      pmOut
);
    import pwr_seq_pkg::*;

    // ************************************************
    // input synchroniser
    // ************************************************
    pins_s  pinMeta_q;
    pins_s  pinSync_q;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= pins;
            pinSync_q <= pinMeta_q;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    logic [2:0]  autoMode_q;
    logic [1:0]  coreTgt_q;
    logic [1:0]  perTgt_q;
    logic        wakeDep_q;
    logic [1:0]  gfxEn_q;
    logic [1:0]  corePrev_q;
    logic [1:0]  perPrev_q;
    logic [1:0]  coreState_q;
    logic [1:0]  perState_q;
    logic [1:0]  coreLatch_q;
    logic [1:0]  perLatch_q;
    logic [31:0] regRdata_q;
    logic        bypass_q;
    logic        idleReq_q;
    logic        memRst_q;
    dpll_e       dState_q;
    dpll_e       dState_d;

    // write decode
    wire wrAuto = regWr && (regAddr == ADDR_AUTO);
    wire wrDom  = regWr && (regAddr == ADDR_DOM);
    wire wrGfx  = regWr && (regAddr == ADDR_GFX);

    // software fields; fields are sampled here on clk and used
    // only at transition boundaries below
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            autoMode_q <= AUTO_RST;
            coreTgt_q  <= PS_ON;
            perTgt_q   <= PS_ON;
            wakeDep_q  <= 1'b0;
            gfxEn_q    <= GFX_RST;
        end else begin
            if (wrAuto) autoMode_q <= regWdata[2:0];
            if (wrDom) begin
                coreTgt_q <= regWdata[DOM_CORE_LSB +: 2];
                perTgt_q  <= regWdata[DOM_PER_LSB +: 2];
                wakeDep_q <= regWdata[DOM_DEP_BIT];
            end
            if (wrGfx) gfxEn_q <= regWdata[1:0];
        end
    end

    // read mux; unmapped addresses read zero
    wire [31:0] statWord = {24'h0, perState_q, coreState_q, 1'b0,
                            idleReq_q, bypass_q, pinSync_q.dpllLocked};
    wire [31:0] rdMux =
        (regAddr == ADDR_AUTO)      ? {29'h0, autoMode_q} :
        (regAddr == ADDR_DOM)       ? {27'h0, wakeDep_q, perTgt_q, coreTgt_q} :
        (regAddr == ADDR_GFX)       ? {30'h0, gfxEn_q} :
        (regAddr == ADDR_PREV_CORE) ? {30'h0, corePrev_q} :
        (regAddr == ADDR_PREV_PER)  ? {30'h0, perPrev_q} :
        (regAddr == ADDR_STAT)      ? statWord : 32'h0;

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) regRdata_q <= 32'h0;
        else         regRdata_q <= regRd ? rdMux : 32'h0;
    end

    // ************************************************
    // power domain sequencing
    // ************************************************
    wire coreOn    = (coreState_q == PS_ON);
    wire perOn     = (perState_q == PS_ON);
    wire coreSleep = pinSync_q.sleepReq && coreOn && (coreTgt_q != PS_ON);
    wire coreAbort = pinSync_q.sleepReq && coreOn && (coreTgt_q == PS_ON);
    wire perSleep  = coreSleep && perOn && (perTgt_q != PS_ON);
    wire coreWakeE = pinSync_q.coreWake && !coreOn;
    // dependency ties peripheral wake to the core wake pin
    wire perWakeE  = !perOn && (pinSync_q.perWake ||
                     (wakeDep_q && pinSync_q.coreWake));
    wire coreDeep  = (coreState_q == PS_OFF) || (coreState_q == PS_OPEN_SWITCH_RETENTION);

    // targets are latched once per transition so a late write
    // cannot change a state already being entered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coreState_q <= PS_ON;
            perState_q  <= PS_ON;
            coreLatch_q <= PS_ON;
            perLatch_q  <= PS_ON;
        end else begin
            if (coreSleep) coreLatch_q <= coreTgt_q;
            if (perSleep)  perLatch_q  <= perTgt_q;
            if (coreSleep)      coreState_q <= coreTgt_q;
            else if (coreWakeE) coreState_q <= PS_ON;
            if (perSleep)       perState_q  <= perTgt_q;
            else if (perWakeE)  perState_q  <= PS_ON;
        end
    end

    // last state entered, written on wake, and for the core also on an aborted sleep
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            corePrev_q <= PS_ON;
            perPrev_q  <= PS_ON;
        end else begin
            if (coreWakeE)      corePrev_q <= coreLatch_q;
            else if (coreAbort) corePrev_q <= PS_ON;
            if (perWakeE)       perPrev_q  <= perLatch_q;
        end
    end

    // memory control reset: core back from off or open-switch,
    // or warm reset; no module soft reset reaches it
    wire memRst_d = pinSync_q.warmReset || (coreWakeE && coreDeep);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) memRst_q <= 1'b0;
        else         memRst_q <= memRst_d;
    end

    // ************************************************
    // dpll control
    // ************************************************
    wire isAuto = (autoMode_q == AUTO_STOP) || (autoMode_q == AUTO_ALT);
    // interface clock enable keeps the tree alive so the dpll
    // must stay locked; functional clock is left out on purpose,
    // so a bypass can slow it unless fed from peripheral_dpll
    wire autoOk  = isAuto && !gfxEn_q[GFX_ICLK_BIT];
    wire wantByp = autoOk && !coreOn;
    wire lockIn  = pinSync_q.dpllLocked;

    // next state; relock waits on the real lock, not a guess
    always_comb begin
        dState_d = dState_q;
        case (dState_q)
            D_LOCK:  if (wantByp) dState_d = D_IDLE;
            D_IDLE:  dState_d = wantByp ? D_BYP : D_RELK;
            D_BYP:   if (!wantByp) dState_d = D_RELK;
            D_RELK:  if (lockIn) dState_d = D_LOCK;
            default: dState_d = D_RELK;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dState_q  <= D_LOCK;
            bypass_q  <= 1'b0;
            idleReq_q <= 1'b0;
        end else begin
            dState_q  <= dState_d;
            bypass_q  <= (dState_d == D_BYP);
            idleReq_q <= (dState_d != D_LOCK);
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign regRdata = regRdata_q;
    assign pmOut    = '{dpllBypass: bypass_q, memIdleReq: idleReq_q,
                        memCtrlReset: memRst_q, coreState: coreState_q,
                        perState: perState_q};

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_auto_leaves_lock: assert property (
        dState_q == D_LOCK && isAuto && !gfxEn_q[GFX_ICLK_BIT] && !coreOn
        |=> dState_q == D_IDLE ##1 bypass_q)
        else $error("auto mode did not start bypass");

    a_manual_stays_lock: assert property (
        autoMode_q == AUTO_MANUAL && dState_q == D_LOCK && !wrAuto
        |=> dState_q == D_LOCK && !bypass_q)
        else $error("manual mode left lock");

    a_iclk_forces_lock: assert property (
        gfxEn_q[GFX_ICLK_BIT] && dState_q == D_LOCK && !wrGfx
        |=> !idleReq_q)
        else $error("interface clock did not hold lock");

    a_memrst_on_wake: assert property (
        coreWakeE && coreDeep |=> memRst_q && coreState_q == PS_ON)
        else $error("no memory reset on deep core wake");

    a_memrst_cause: assert property (
        memRst_q |-> $past(pinSync_q.warmReset) || $past(coreWakeE && coreDeep))
        else $error("memory reset without cause");

    a_dep_wake: assert property (
        wakeDep_q && pinSync_q.coreWake && !coreOn && !perOn && !perSleep
        |=> perOn && coreOn)
        else $error("peripheral did not wake with core");

    a_prev_record: assert property (
        coreWakeE |=> corePrev_q == $past(coreLatch_q) ##1 $stable(corePrev_q) || coreAbort)
        else $error("previous core state not recorded");

    a_idle_until_lock: assert property (
        idleReq_q && !lockIn && dState_q != D_IDLE |=> idleReq_q)
        else $error("idle request dropped before lock");

    a_target_boundary: assert property (
        coreOn && !pinSync_q.sleepReq |=> coreOn)
        else $error("core left on outside a sleep boundary");

    c_bypass_seen: cover property (dState_q == D_LOCK ##1 dState_q == D_IDLE ##1 bypass_q);
    c_relock_done: cover property (dState_q == D_RELK ##[1:20] dState_q == D_LOCK);
    c_dep_wake:    cover property (wakeDep_q && perWakeE && coreWakeE);

endmodule

//--- tb/test_core_dpll_power_domain_sequencer.sv
// self-checking bench for the core dpll and power domain sequencer
`timescale 1ns/1ps
module test_core_dpll_power_domain_sequencer;
    import pwr_seq_pkg::*;

    // ************************************************************
    // signals and design instance
    // ************************************************************
    logic          clk;
    logic          resetn;
    logic [7:0]    regAddr;
    logic [31:0]   regWdata;
    logic          regWr;
    logic          regRd;
    logic [31:0]   regRdata;
    pins_s         pins;
    pmOut_s        pmOut;
    int            nFail;
    int            checksDone;
    logic          sawRst;
    logic          clrRst;

    core_dpll_power_domain_sequencer dut_u (
        .clk      (clk),
        .resetn   (resetn),
        .regAddr  (regAddr),
        .regWdata (regWdata),
        .regWr    (regWr),
        .regRd    (regRd),
        .regRdata (regRdata),
        .pins     (pins),
        .pmOut    (pmOut)
    );

    // clock at 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // the reset pulse is one cycle, so a sticky flag keeps it for a later look
    // one process owns the flag; the main sequence only asks for a clear
    always @(posedge clk) begin
        if (clrRst) sawRst <= 1'b0;
        else if (pmOut.memCtrlReset === 1'b1) sawRst <= 1'b1;
    end

    // ************************************************************
    // access and compare tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        check(regRdata, exp, "register read");
    endtask

    // bounded wait on the core state
    task automatic waitCore(input logic [1:0] st);
        int n;
        n = 0;
        while (pmOut.coreState !== st && n < 60) begin
            @(posedge clk);
            n++;
        end
        #1;
        check({30'h0, pmOut.coreState}, {30'h0, st}, "core state wait");
    endtask

    // one sleep and wake round with a given auto code and graphics enables
    task automatic sleepWake(input logic [2:0] code, input logic [1:0] gfx, input logic expByp);
        wr(ADDR_AUTO, {29'h0, code});
        wr(ADDR_GFX, {30'h0, gfx});
        wr(ADDR_DOM, 32'h0000_0010);
        pins.sleepReq <= 1'b1;
        waitCore(PS_OFF);
        repeat (4) @(posedge clk);
        #1;
        check({31'h0, pmOut.dpllBypass}, {31'h0, expByp}, "bypass in sleep");
        pins.sleepReq <= 1'b0;
        if (expByp) pins.dpllLocked <= 1'b0;
        clrRst <= 1'b1;
        @(posedge clk);
        clrRst <= 1'b0;
        repeat (3) @(posedge clk);
        pins.coreWake <= 1'b1;
        waitCore(PS_ON);
        pins.coreWake <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({30'h0, pmOut.perState}, {30'h0, PS_ON}, "peripheral woke with core");
        check({31'h0, sawRst}, 32'h1, "memory control reset on core wake");
        if (expByp) begin
            repeat (8) @(posedge clk);
            #1;
            check({31'h0, pmOut.memIdleReq}, 32'h1, "idle held until lock");
            pins.dpllLocked <= 1'b1;
            repeat (5) @(posedge clk);
            #1;
            check({31'h0, pmOut.memIdleReq}, 32'h0, "idle released after lock");
        end
        rd(ADDR_PREV_CORE, {30'h0, PS_OFF});
        rd(ADDR_PREV_PER, {30'h0, PS_OFF});
        wr(ADDR_AUTO, 32'h0);
        $display("round with auto code %0d done", code);
    endtask

    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    // a hang past about fifty times the expected run counts as a mismatch
    initial begin
        #60000;
        nFail++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        completeRun();
    end

    initial begin
        nFail = 0;
        checksDone = 0;
        clrRst = 1'b0;
        resetn = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        pins = '0;
        pins.dpllLocked = 1'b1;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values and an unmapped place
        rd(ADDR_AUTO, {29'h0, AUTO_RST});
        rd(ADDR_DOM, 32'h0000_000F);
        rd(ADDR_GFX, {30'h0, GFX_RST});
        rd(ADDR_PREV_PER, {30'h0, PS_ON});
        rd(ADDR_STAT, 32'h0000_00F1);
        wr(8'h20, 32'h0000_0005);
        rd(8'h20, 32'h0);
        rd(ADDR_AUTO, 32'h0);
        $display("reset and map test done");
        // auto codes, manual, and graphics clock effects
        sleepWake(AUTO_STOP, 2'h0, 1'b1);
        sleepWake(AUTO_ALT, 2'h0, 1'b1);
        sleepWake(AUTO_MANUAL, 2'h0, 1'b0);
        sleepWake(AUTO_STOP, 2'h1, 1'b1);
        sleepWake(AUTO_STOP, 2'h2, 1'b0);
        sleepWake(AUTO_MANUAL, 2'h1, 1'b0);
        // a sleep request with the core target on is an abort
        wr(ADDR_DOM, 32'h0000_000F);
        pins.sleepReq <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check({30'h0, pmOut.coreState}, {30'h0, PS_ON}, "aborted sleep keeps core on");
        pins.sleepReq <= 1'b0;
        rd(ADDR_PREV_CORE, {30'h0, PS_ON});
        $display("abort test done");
        // warm reset holds the memory control reset
        pins.warmReset <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({31'h0, pmOut.memCtrlReset}, 32'h1, "warm reset level");
        pins.warmReset <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check({31'h0, pmOut.memCtrlReset}, 32'h0, "warm reset released");
        $display("warm reset test done");
        completeRun();
    end
endmodule
